/* design/iowd_regs.svh */
// Purpose: constants shared by both ends of the i/o window decode link
// Assumes: 100 MHz core clock, byte-wide data, 12-bit address
// Notes: all offsets, field positions and counts are named here
// Summary of operation
// - host gives each card eight-byte window
// - host aligns window base to eight bytes
// - independent window belongs to one card only
// - card ignores i/o until configured
// - written entry index selects mode and range
// - selected entry chooses independent or overlapping
// - independent mode decodes only low port bits
// - overlapping mode answers own subset only
// - overlapping subsets never overlap each other
// - card decodes address set host selected
// - host window fixed or allocated at detect
// - host reserves 128 contiguous i/o bytes
// - config register n sits at base plus 2n
// - reset line or soft reset clears decode
`ifndef IOWD_REGS_SVH
`define IOWD_REGS_SVH

`define IOWD_ADDR_W 12
`define IOWD_DATA_W 8
`define IOWD_PORTS 8
`define IOWD_WIN_BYTES 8
`define IOWD_WIN_ALIGN_BITS 3
`define IOWD_RESV_BYTES 128
`define IOWD_RESV_BASE 12'h100

// attribute space holding the function configuration registers
`define IOWD_CFG_BASE 12'h200
`define IOWD_CFG_COUNT 16
`define IOWD_CFG_STRIDE 2
`define IOWD_OPT_REG_N 4'h0
`define IOWD_STAT_REG_N 4'h1
`define IOWD_OPT_IDX_LSB 0
`define IOWD_OPT_IDX_W 6
`define IOWD_OPT_SRST_BIT 7
`define IOWD_STAT_CFG_BIT 0
`define IOWD_STAT_OVL_BIT 1
`define IOWD_OPT_RESET 8'h00

// configuration table: entry 1 independent, 2..4 overlapping sets
`define IOWD_ENT_INDEP 6'h01
`define IOWD_ENT_OVL_A 6'h02
`define IOWD_ENT_OVL_B 6'h03
`define IOWD_ENT_OVL_C 6'h04
`define IOWD_OVL_MASK 12'hff8
`define IOWD_OVL_A_BASE 12'h2f8
`define IOWD_OVL_B_BASE 12'h3f8
`define IOWD_OVL_C_BASE 12'h2e8

// shared overlapping block seen by the host
`define IOWD_OVL_BLK_BASE 12'h200
`define IOWD_OVL_BLK_BYTES 768

// strobe timing
`define IOWD_CLK_NS 10
`define IOWD_STROBE_NS 100
`define IOWD_STROBE_CYC ((`IOWD_STROBE_NS + `IOWD_CLK_NS - 1) / `IOWD_CLK_NS)

`define IOWD_FLOAT_DATA 8'hff

`endif

/* design/iowd_pkg.sv */
// Purpose: types for the i/o window decode link
// Assumes: iowd_regs.svh holds the numbers
// Notes: enums carry no codes on purpose
package iowd_pkg;
   // decode mode chosen by the selected entry
   typedef enum logic [1:0] {
      IOWD_MODE_NONE,
      IOWD_MODE_INDEP,
      IOWD_MODE_OVL
   } iowd_mode_type;

   // host command kinds
   typedef enum logic [1:0] {
      IOWD_CMD_IO_RD,
      IOWD_CMD_IO_WR,
      IOWD_CMD_ATTR_RD,
      IOWD_CMD_ATTR_WR
   } iowd_cmd_type;

   // host cycle sequencer
   typedef enum logic [1:0] {
      IOWD_ST_IDLE,
      IOWD_ST_SETUP,
      IOWD_ST_STROBE,
      IOWD_ST_HOLD
   } iowd_state_type;
endpackage

/* design/iowd_if.sv */
// Purpose: socket wires between host controller and card
// Assumes: both ends on i_core_clk, wires sampled synchronously
// Notes: data bus resolved here from the two output enables
`timescale 1ns/1ps
`include "iowd_regs.svh"
interface iowd_if #(
   parameter int ADDR_W = `IOWD_ADDR_W,
   parameter int DATA_W = `IOWD_DATA_W
);
   logic [ADDR_W-1:0] addr; // address lines
   logic ce_n; // card enable, low active
   logic reg_n; // attribute / i/o space select, low active
   logic iord_n; // i/o read strobe
   logic iowr_n; // i/o write strobe
   logic oe_n; // attribute read strobe
   logic we_n; // attribute write strobe
   logic card_reset; // reset line, high active
   logic [DATA_W-1:0] d_host; // host data drive
   logic d_host_oe; // host drives data
   logic [DATA_W-1:0] d_card; // card data drive
   logic d_card_oe; // card drives data
   logic [DATA_W-1:0] d; // resolved bus level

   // pull-downs win when neither side drives
   assign d = d_card_oe ? d_card : (d_host_oe ? d_host : '0);

   modport host (
      output addr, ce_n, reg_n, iord_n, iowr_n, oe_n, we_n, card_reset,
      output d_host, d_host_oe,
      input d, d_card_oe
   );
   modport card (
      input addr, ce_n, reg_n, iord_n, iowr_n, oe_n, we_n, card_reset,
      input d, d_host_oe,
      output d_card, d_card_oe
   );
endinterface

/* design/iowd_card.sv */
// Purpose: card end, i/o address window decode and config registers
// Assumes: socket wires synchronous to i_core_clk
// Notes: read data and enable are registered, one cycle behind strobe
`timescale 1ns/1ps
`include "iowd_regs.svh"
module iowd_card
   import iowd_pkg::*;
#(
   parameter int ADDR_W = `IOWD_ADDR_W,
   parameter int DATA_W = `IOWD_DATA_W,
   parameter int PORTS = `IOWD_PORTS,
   parameter int PORT_W = $clog2(PORTS)
) (
   input wire logic i_core_clk, // core clock
   input wire logic i_resetn, // async reset, low active
   iowd_if.card bus, // socket side
   input wire logic [DATA_W-1:0] i_user_status, // value read at last port
   output logic [`IOWD_OPT_IDX_W-1:0] o_cfg_index, // selected entry
   output iowd_mode_type o_mode, // active decode mode
   output logic o_configured, // card answers i/o
   output logic o_wr_valid, // one-cycle pulse per i/o write
   output logic [PORT_W-1:0] o_wr_port, // port written
   output logic [DATA_W-1:0] o_wr_data // data written
);

   // table entry decode: mode of one index
   function automatic iowd_mode_type entry_mode(input logic [`IOWD_OPT_IDX_W-1:0] idx);
      iowd_mode_type m;
      m = IOWD_MODE_NONE;
      if (idx == `IOWD_ENT_INDEP) begin
         m = IOWD_MODE_INDEP;
      end else if (idx == `IOWD_ENT_OVL_A || idx == `IOWD_ENT_OVL_B ||
                   idx == `IOWD_ENT_OVL_C) begin
         m = IOWD_MODE_OVL;
      end
      return m;
   endfunction

   // table entry decode: base of the overlapping subset
   function automatic logic [ADDR_W-1:0] entry_base(input logic [`IOWD_OPT_IDX_W-1:0] idx);
      logic [ADDR_W-1:0] b;
      b = `IOWD_OVL_A_BASE;
      if (idx == `IOWD_ENT_OVL_B) begin
         b = `IOWD_OVL_B_BASE;
      end else if (idx == `IOWD_ENT_OVL_C) begin
         b = `IOWD_OVL_C_BASE;
      end
      return b;
   endfunction

   // state
   logic [`IOWD_OPT_IDX_W-1:0] idx_q; // selected entry, zero = unconfigured
   logic [`IOWD_OPT_IDX_W-1:0] idx_d;
   logic [DATA_W-1:0] port_q [PORTS]; // implemented i/o ports
   logic iowr_seen_q; // i/o write strobe seen last cycle
   logic we_seen_q; // attribute write strobe seen last cycle
   logic [DATA_W-1:0] rdata_q; // data drive
   logic [DATA_W-1:0] rdata_d;
   logic rd_oe_q; // data enable
   logic rd_oe_d;
   logic wr_valid_q; // write notice to user
   logic [PORT_W-1:0] wr_port_q;
   logic [DATA_W-1:0] wr_data_q;

   // socket decode
   wire card_sel = !bus.ce_n && !bus.reg_n; // card and space selected
   wire io_rd = card_sel && !bus.iord_n; // i/o read strobe live
   wire io_wr = card_sel && !bus.iowr_n; // i/o write strobe live
   wire at_rd = card_sel && !bus.oe_n; // attribute read strobe live
   wire at_wr = card_sel && !bus.we_n; // attribute write strobe live
   // one write per strobe, even if it is held many cycles
   wire io_wr_start = io_wr && !iowr_seen_q;
   wire at_wr_start = at_wr && !we_seen_q;

   // configuration register window in attribute space
   wire [ADDR_W-1:0] cfg_off = bus.addr - ADDR_W'(`IOWD_CFG_BASE);
   wire cfg_in = (bus.addr >= ADDR_W'(`IOWD_CFG_BASE)) &&
                 (cfg_off < ADDR_W'(`IOWD_CFG_COUNT * `IOWD_CFG_STRIDE));
   wire cfg_even = !cfg_off[0];
   wire [3:0] cfg_n = cfg_off[4:1];
   wire cfg_hit = cfg_in && cfg_even;
   wire opt_sel = cfg_hit && (cfg_n == `IOWD_OPT_REG_N);
   wire stat_sel = cfg_hit && (cfg_n == `IOWD_STAT_REG_N);

   wire soft_reset_bit = at_wr_start && opt_sel && bus.d[`IOWD_OPT_SRST_BIT];
   wire clr = bus.card_reset || soft_reset_bit;

   wire iowd_mode_type mode = entry_mode(idx_q);
   wire [ADDR_W-1:0] ovl_base = entry_base(idx_q);
   wire configured = (mode != IOWD_MODE_NONE) && !bus.card_reset;

   wire ovl_match = (bus.addr & ADDR_W'(`IOWD_OVL_MASK)) == ovl_base;
   wire indep_match = (mode == IOWD_MODE_INDEP);
   wire addr_match = indep_match || ((mode == IOWD_MODE_OVL) && ovl_match);
   wire io_rd_hit = configured && io_rd && addr_match;
   wire io_wr_hit = configured && io_wr_start && addr_match;
   wire [PORT_W-1:0] port_sel = bus.addr[PORT_W-1:0];
   // last port reads user status instead of its latch
   wire [DATA_W-1:0] port_rd = (port_sel == PORT_W'(PORTS - 1)) ?
                               i_user_status : port_q[port_sel];

   // configuration reads: option, status, unimplemented read zero
   wire [DATA_W-1:0] opt_rd = DATA_W'(idx_q) << `IOWD_OPT_IDX_LSB;
   wire [DATA_W-1:0] stat_rd = (DATA_W'(configured) << `IOWD_STAT_CFG_BIT) |
                               (DATA_W'(mode == IOWD_MODE_OVL) << `IOWD_STAT_OVL_BIT);
   wire [DATA_W-1:0] cfg_rd = opt_sel ? opt_rd : (stat_sel ? stat_rd : '0);
   // attribute reads answered at even places in the config window, even unconfigured, but not while the reset line is high
   wire at_rd_hit = at_rd && cfg_hit && !bus.card_reset;

   // next entry index
   always_comb begin
      idx_d = idx_q;
      if (clr) begin
         // power-up state: no decode
         idx_d = '0;
      end else if (at_wr_start && opt_sel) begin
         idx_d = bus.d[`IOWD_OPT_IDX_LSB +: `IOWD_OPT_IDX_W];
      end
   end

   // next read drive
   always_comb begin
      rdata_d = '0;
      rd_oe_d = 1'b0;
      if (io_rd_hit) begin
         rdata_d = port_rd;
         rd_oe_d = 1'b1;
      end else if (at_rd_hit) begin
         rdata_d = cfg_rd;
         rd_oe_d = 1'b1;
      end
   end

   // configuration and strobe history
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         idx_q <= (`IOWD_OPT_IDX_W)'(`IOWD_OPT_RESET);
         iowr_seen_q <= 1'b0;
         we_seen_q <= 1'b0;
      end else begin
         idx_q <= idx_d;
         iowr_seen_q <= io_wr;
         we_seen_q <= at_wr;
      end
   end

   // port latches; reset wipes them with the decode
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int i = 0; i < PORTS; i++) begin
            port_q[i] <= '0;
         end
      end else if (clr) begin
         for (int i = 0; i < PORTS; i++) begin
            port_q[i] <= '0;
         end
      end else if (io_wr_hit) begin
         port_q[port_sel] <= bus.d;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_q <= '0;
         rd_oe_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rd_oe_q <= rd_oe_d;
      end
   end

   // write notice toward the card's function logic
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_valid_q <= 1'b0;
         wr_port_q <= '0;
         wr_data_q <= '0;
      end else begin
         wr_valid_q <= io_wr_hit;
         if (io_wr_hit) begin
            wr_port_q <= port_sel;
            wr_data_q <= bus.d;
         end
      end
   end

   // the enable drops one cycle after the strobe; the host holds
   // its address one cycle past the strobe so no contention follows
   assign bus.d_card = rdata_q;
   assign bus.d_card_oe = rd_oe_q;

   assign o_cfg_index = idx_q;
   assign o_mode = mode;
   assign o_configured = configured;
   assign o_wr_valid = wr_valid_q;
   assign o_wr_port = wr_port_q;
   assign o_wr_data = wr_data_q;

endmodule // iowd_card

/* design/iowd_host.sv */
// Purpose: host socket controller end, runs i/o and attribute cycles
// Assumes: one command at a time, no wait states from the card
// Notes: refuses i/o outside its windows without touching the bus
`timescale 1ns/1ps
`include "iowd_regs.svh"
module iowd_host
   import iowd_pkg::*;
#(
   parameter int ADDR_W = `IOWD_ADDR_W,
   parameter int DATA_W = `IOWD_DATA_W,
   parameter int STROBE_CYC = `IOWD_STROBE_CYC
) (
   input wire logic i_core_clk, // core clock
   input wire logic i_resetn, // async reset, low active
   iowd_if.host bus, // socket side
   input wire logic i_card_reset, // level: hold card in reset
   input wire logic [ADDR_W-1:0] i_win_base, // window base for this socket
   input wire logic i_cmd_valid, // command offered
   input wire iowd_cmd_type i_cmd_kind, // command kind
   input wire logic [ADDR_W-1:0] i_cmd_addr, // command address
   input wire logic [DATA_W-1:0] i_cmd_wdata, // write data
   output logic o_cmd_ready, // command accepted when valid
   output logic o_rsp_valid, // one-cycle completion pulse
   output logic [DATA_W-1:0] o_rsp_data, // read data
   output logic o_rsp_refused // command ran no bus cycle
);

   iowd_state_type st_q, st_d;
   logic [$clog2(STROBE_CYC+1)-1:0] cnt_q; // strobe cycles left after this one
   iowd_cmd_type kind_q; // command in flight
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [DATA_W-1:0] rsp_data_q;
   logic rsp_valid_q;
   logic refused_q;
   logic reset_q; // reset line drive

   wire [ADDR_W-1:0] align_mask = ~ADDR_W'(`IOWD_WIN_BYTES - 1);
   wire in_win = (i_cmd_addr & align_mask) == (i_win_base & align_mask);
   wire in_ovl = (i_cmd_addr >= ADDR_W'(`IOWD_OVL_BLK_BASE)) &&
                 (i_cmd_addr < ADDR_W'(`IOWD_OVL_BLK_BASE + `IOWD_OVL_BLK_BYTES));
   // reserved many-port block
   // a card needing many ports is placed here, so the host passes its cycles
   wire in_resv = (i_cmd_addr >= ADDR_W'(`IOWD_RESV_BASE)) &&
                  (i_cmd_addr < ADDR_W'(`IOWD_RESV_BASE + `IOWD_RESV_BYTES));
   wire is_io = (i_cmd_kind == IOWD_CMD_IO_RD) || (i_cmd_kind == IOWD_CMD_IO_WR);
   wire io_ok = in_win || in_ovl || in_resv;
   wire accept = o_cmd_ready && i_cmd_valid;
   wire refuse = accept && is_io && !io_ok;
   wire start = accept && !refuse;
   wire strobe = (st_q == IOWD_ST_STROBE);
   wire last = strobe && (cnt_q == '0);
   wire is_wr = (kind_q == IOWD_CMD_IO_WR) || (kind_q == IOWD_CMD_ATTR_WR);

   // cycle sequencer
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         IOWD_ST_IDLE: if (start) st_d = IOWD_ST_SETUP;
         IOWD_ST_SETUP: st_d = IOWD_ST_STROBE;
         IOWD_ST_STROBE: if (last) st_d = IOWD_ST_HOLD;
         IOWD_ST_HOLD: st_d = IOWD_ST_IDLE;
      endcase
   end

   // state, command capture, strobe counter
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_q <= IOWD_ST_IDLE;
         cnt_q <= '0;
         kind_q <= IOWD_CMD_IO_RD;
         addr_q <= '0;
         wdata_q <= '0;
      end else begin
         st_q <= st_d;
         if (start) begin
            kind_q <= i_cmd_kind;
            addr_q <= i_cmd_addr;
            wdata_q <= i_cmd_wdata;
         end
         if (st_q == IOWD_ST_SETUP) begin
            cnt_q <= ($bits(cnt_q))'(STROBE_CYC - 1);
         end else if (strobe && !last) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   // response: sample at the last strobe cycle, pulse in hold
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rsp_data_q <= '0;
         rsp_valid_q <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         rsp_valid_q <= refuse || last;
         refused_q <= refuse;
         if (refuse) begin
            rsp_data_q <= `IOWD_FLOAT_DATA;
         end else if (last) begin
            rsp_data_q <= is_wr ? '0 : bus.d;
         end
      end
   end

   // reset line held high while the host itself is in reset
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         reset_q <= 1'b1;
      end else begin
         reset_q <= i_card_reset;
      end
   end

   wire busy = (st_q != IOWD_ST_IDLE);
   assign bus.addr = addr_q;
   assign bus.ce_n = !busy;
   assign bus.reg_n = !busy;
   assign bus.iord_n = !(strobe && kind_q == IOWD_CMD_IO_RD);
   assign bus.iowr_n = !(strobe && kind_q == IOWD_CMD_IO_WR);
   assign bus.oe_n = !(strobe && kind_q == IOWD_CMD_ATTR_RD);
   assign bus.we_n = !(strobe && kind_q == IOWD_CMD_ATTR_WR);
   assign bus.card_reset = reset_q;
   assign bus.d_host = wdata_q;
   assign bus.d_host_oe = busy && is_wr;

   assign o_cmd_ready = !busy && !reset_q && !rsp_valid_q;
   assign o_rsp_valid = rsp_valid_q;
   assign o_rsp_data = rsp_data_q;
   assign o_rsp_refused = refused_q;

endmodule // iowd_host

/* tb/iowd_properties.sv */
// Purpose: socket link checker for the i/o window decode pair
// Assumes: one clock domain, i_resetn async low, no wait states
// Notes: the selected entry is rebuilt by snooping option writes
`timescale 1ns/1ps
`include "iowd_regs.svh"
module iowd_properties (
   input wire logic i_core_clk, // core clock
   input wire logic i_resetn, // async reset, low active
   input wire logic [`IOWD_ADDR_W-1:0] addr, // address lines
   input wire logic ce_n, // card enable
   input wire logic reg_n, // space select
   input wire logic iord_n, // i/o read strobe
   input wire logic iowr_n, // i/o write strobe
   input wire logic oe_n, // attribute read strobe
   input wire logic we_n, // attribute write strobe
   input wire logic card_reset, // reset line
   input wire logic [`IOWD_DATA_W-1:0] d, // resolved data
   input wire logic d_host_oe, // host drives data
   input wire logic [`IOWD_DATA_W-1:0] d_card, // card data
   input wire logic d_card_oe // card drives data
);
   logic [5:0] idx_q; // snooped entry index
   logic [5:0] idx_d; // next entry index
   logic we_q; // write strobe one cycle ago
   wire sel = !ce_n && !reg_n; // card and space selected
   wire opt_wr = sel && !we_n && we_q && addr == `IOWD_CFG_BASE; // first write cycle
   wire indep = idx_q == `IOWD_ENT_INDEP; // independent entry
   wire ovl = idx_q >= `IOWD_ENT_OVL_A && idx_q <= `IOWD_ENT_OVL_C; // overlap entries
   wire [11:0] ovl_base = idx_q == `IOWD_ENT_OVL_A ? `IOWD_OVL_A_BASE :
      (idx_q == `IOWD_ENT_OVL_B ? `IOWD_OVL_B_BASE : `IOWD_OVL_C_BASE); // subset base
   wire io_hit = !card_reset && (indep || (ovl && (addr & `IOWD_OVL_MASK) == ovl_base));
   wire attr_hit = !addr[0] && addr >= `IOWD_CFG_BASE && addr < `IOWD_CFG_BASE + 12'h020;
   // reset wins over a write in the same cycle, soft reset drops the index
   assign idx_d = card_reset ? 6'h00 : (opt_wr ? (d[7] ? 6'h00 : d[5:0]) : idx_q);
   // snoop register, kept separate so the card's own flops are not trusted
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         idx_q <= 6'h00;
         we_q <= 1'b1;
      end else begin
         idx_q <= idx_d;
         we_q <= we_n;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   property p_rst_quiet; card_reset |=> !d_card_oe; endproperty
   property p_no_io_rst; card_reset |-> iord_n && iowr_n; endproperty
   property p_drv_cause; d_card_oe |-> $past(sel && (!iord_n || !oe_n)); endproperty
   property p_drv_drop; $rose(iord_n) || $rose(oe_n) |=> !d_card_oe; endproperty
   property p_one_drv; !(d_card_oe && d_host_oe); endproperty
   property p_io_match; sel && !iord_n && $past(!iord_n) |-> d_card_oe == io_hit; endproperty
   property p_attr_ans; sel && !oe_n && $past(!oe_n) |-> d_card_oe == attr_hit; endproperty
   property p_opt_data;
      sel && !oe_n && $past(!oe_n) && addr == `IOWD_CFG_BASE |-> d_card == {2'b00, idx_q};
   endproperty
   property p_stat_data;
      sel && !oe_n && $past(!oe_n) && addr == `IOWD_CFG_BASE + 12'h002
         |-> d_card[1:0] == {ovl, indep || ovl};
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("card drove data in reset");
   a_no_io_rst: assert property (p_no_io_rst) else $error("i/o strobe in reset");
   a_drv_cause: assert property (p_drv_cause) else $error("card drove without read");
   a_drv_drop: assert property (p_drv_drop) else $error("card kept driving");
   a_one_drv: assert property (p_one_drv) else $error("both ends drive data");
   a_io_match: assert property (p_io_match) else $error("i/o decode mismatch");
   a_attr_ans: assert property (p_attr_ans) else $error("config place mismatch");
   a_opt_data: assert property (p_opt_data) else $error("option readback wrong");
   a_stat_data: assert property (p_stat_data) else $error("status mode wrong");
   c_io_hit: cover property (sel && !iord_n && io_hit);
   c_opt_wr: cover property (opt_wr && !d[7]);
   c_soft_rst: cover property (opt_wr && d[7]);
endmodule // iowd_properties

/* tb/tb_io_window_address_decode.sv */
// Purpose: self-checking bench, host and card joined across the socket
// Assumes: default strobe length, host window outside the shared block
// Notes: each scenario drives the host command port and judges replies
`timescale 1ns/1ps
`include "iowd_regs.svh"
module tb_io_window_address_decode import iowd_pkg::*;;
   localparam logic [11:0] WIN = 12'h0f0; // independent window base
   localparam logic [11:0] CB = `IOWD_CFG_BASE; // option register place
   logic clk = 1'b0; // core clock
   logic rstn = 1'b0; // reset, low active
   logic card_rst = 1'b0; // card reset request
   logic cmd_valid = 1'b0; // command offered
   iowd_cmd_type cmd_kind = IOWD_CMD_IO_RD; // command kind
   logic [11:0] cmd_addr = 12'h000; // command address
   logic [7:0] cmd_wdata = 8'h00; // write data
   logic [7:0] user_status = 8'h96; // last port value
   logic cmd_ready, rsp_valid, rsp_refused, configured, wr_valid; // host and card flags
   logic [7:0] rsp_data, wr_data; // returned bytes
   logic [5:0] cfg_index; // selected entry
   iowd_mode_type mode; // card decode mode
   logic [2:0] wr_port; // written port
   int err_total = 0; // mismatches
   int checks = 0; // comparisons
   int wr_cnt = 0; // card write pulses seen
   iowd_if bus_if ();
   iowd_host i_iowd_host (.i_core_clk(clk), .i_resetn(rstn), .bus(bus_if),
      .i_card_reset(card_rst), .i_win_base(WIN), .i_cmd_valid(cmd_valid),
      .i_cmd_kind(cmd_kind), .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata),
      .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
      .o_rsp_refused(rsp_refused));
   iowd_card i_iowd_card (.i_core_clk(clk), .i_resetn(rstn), .bus(bus_if),
      .i_user_status(user_status), .o_cfg_index(cfg_index), .o_mode(mode),
      .o_configured(configured), .o_wr_valid(wr_valid), .o_wr_port(wr_port),
      .o_wr_data(wr_data));
   iowd_properties u_chk (.i_core_clk(clk), .i_resetn(rstn), .addr(bus_if.addr),
      .ce_n(bus_if.ce_n), .reg_n(bus_if.reg_n), .iord_n(bus_if.iord_n),
      .iowr_n(bus_if.iowr_n), .oe_n(bus_if.oe_n), .we_n(bus_if.we_n),
      .card_reset(bus_if.card_reset), .d(bus_if.d), .d_host_oe(bus_if.d_host_oe),
      .d_card(bus_if.d_card), .d_card_oe(bus_if.d_card_oe));
   // 100 mhz clock
   initial begin
      forever #5 clk = ~clk;
   end
   // count write pulses; a pulse stands one cycle so the negedge sees it
   always @(negedge clk) begin
      if (wr_valid === 1'b1) wr_cnt++;
   end
   task automatic results();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one host command; valid held until the edge that takes it
   task automatic cmd(input iowd_cmd_type k, input logic [11:0] a, input logic [7:0] w);
      int n = 0;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_kind <= k;
      cmd_addr <= a;
      cmd_wdata <= w;
      do @(negedge clk); while (cmd_ready !== 1'b1 && n++ < 60);
      @(posedge clk);
      cmd_valid <= 1'b0;
      do @(negedge clk); while (rsp_valid !== 1'b1 && n++ < 80);
      chk("handshake", 8'h00, 8'(n >= 80));
   endtask
   // fresh card answers configuration only
   task automatic t_unconf();
      int c = wr_cnt;
      cmd(IOWD_CMD_IO_RD, WIN + 12'h007, 8'h00);
      chk("unconf read", 8'h00, rsp_data);
      cmd(IOWD_CMD_IO_WR, WIN + 12'h003, 8'h3c);
      chk("unconf write", 8'(c), 8'(wr_cnt));
      cmd(IOWD_CMD_ATTR_RD, CB + 12'h002, 8'h00);
      chk("unconf status", 8'h00, rsp_data);
   endtask
   // independent entry: low bits pick the port
   task automatic t_indep();
      int c;
      cmd(IOWD_CMD_ATTR_WR, CB, 8'h01);
      cmd(IOWD_CMD_ATTR_RD, CB, 8'h00);
      chk("option", 8'h01, rsp_data);
      cmd(IOWD_CMD_ATTR_RD, CB + 12'h002, 8'h00);
      chk("status indep", 8'h01, rsp_data);
      cmd(IOWD_CMD_ATTR_RD, CB + 12'h001, 8'h00);
      chk("odd place", 8'h00, rsp_data);
      chk("configured", 8'h01, 8'(configured));
      chk("cfg index", 8'h01, 8'(cfg_index));
      chk("mode indep", 8'(IOWD_MODE_INDEP), 8'(mode));
      cmd(IOWD_CMD_IO_RD, WIN + 12'h007, 8'h00);
      chk("port7 read", user_status, rsp_data);
      c = wr_cnt;
      cmd(IOWD_CMD_IO_WR, WIN + 12'h005, 8'h5a);
      chk("write port", 8'h05, 8'(wr_port));
      cmd(IOWD_CMD_IO_WR, WIN + 12'h002, 8'ha5);
      chk("write data", 8'ha5, wr_data);
      chk("write count", 8'(c + 2), 8'(wr_cnt));
      cmd(IOWD_CMD_IO_RD, WIN + 12'h005, 8'h00);
      chk("port5 read", 8'h5a, rsp_data);
      cmd(IOWD_CMD_IO_RD, `IOWD_RESV_BASE + 12'h07f, 8'h00);
      chk("reserved read", user_status, rsp_data);
      chk("reserved taken", 8'h00, 8'(rsp_refused));
      cmd(IOWD_CMD_IO_RD, 12'h180, 8'h00);
      chk("refused", 8'h01, 8'(rsp_refused));
      chk("refused data", `IOWD_FLOAT_DATA, rsp_data);
   endtask
   // each overlapping set answers its own subset only
   task automatic t_ovl();
      logic [11:0] b[3] = '{`IOWD_OVL_A_BASE, `IOWD_OVL_B_BASE, `IOWD_OVL_C_BASE};
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         user_status <= 8'hc0 + 8'(i);
         cmd(IOWD_CMD_ATTR_WR, CB, 8'(`IOWD_ENT_OVL_A + i));
         cmd(IOWD_CMD_ATTR_RD, CB + 12'h002, 8'h00);
         chk("status ovl", 8'h03, rsp_data);
         chk("mode ovl", 8'(IOWD_MODE_OVL), 8'(mode));
         cmd(IOWD_CMD_IO_RD, b[i] + 12'h007, 8'h00);
         chk("ovl hit", 8'hc0 + 8'(i), rsp_data);
         cmd(IOWD_CMD_IO_RD, b[(i + 1) % 3] + 12'h007, 8'h00);
         chk("ovl miss", 8'h00, rsp_data);
      end
   endtask
   // soft reset, bad entry and reset line all leave the card silent
   task automatic t_reset();
      cmd(IOWD_CMD_ATTR_WR, CB, 8'h81);
      cmd(IOWD_CMD_ATTR_RD, CB + 12'h002, 8'h00);
      chk("soft reset", 8'h00, rsp_data);
      cmd(IOWD_CMD_ATTR_WR, CB, 8'h05);
      cmd(IOWD_CMD_IO_RD, WIN + 12'h007, 8'h00);
      chk("bad entry", 8'h00, rsp_data);
      cmd(IOWD_CMD_ATTR_WR, CB, 8'h01);
      @(posedge clk);
      card_rst <= 1'b1;
      repeat (4) @(posedge clk);
      card_rst <= 1'b0;
      cmd(IOWD_CMD_ATTR_RD, CB, 8'h00);
      chk("line reset", 8'h00, rsp_data);
      cmd(IOWD_CMD_IO_RD, WIN + 12'h007, 8'h00);
      chk("after reset", 8'h00, rsp_data);
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      t_unconf();
      t_indep();
      t_ovl();
      t_reset();
      results();
   end
   // hang guard, well past the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("[FAIL] watchdog expired");
      results();
   end
endmodule // tb_io_window_address_decode
